//--- include/fpc_pkg.sv
// Purpose: shared constants for the parallel flash command host controller
// Assumes: 50 MHz aclk, byte-wide flash with 19 address lines
// Notes: unlock addresses and command codes are set here for the whole design
package fpc_pkg;
  // array geometry
  localparam int ARRAY_BYTES = 524288;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int NUM_SECT = 8;
  localparam int SECT_LSB = 16;
  localparam int SECT_W = ADDR_W - SECT_LSB;

  // bus timing, in ns, and the cycle counts taken from them (least times round up)
  localparam int CLK_NS = 20;
  localparam int T_AS_NS = 20;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_HOLD_NS = 20;
  localparam logic [3:0] AS_CYC = 4'((T_AS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_SECT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1C;

  // field positions
  localparam int CTRL_OP_W = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_RESULT_LSB = 8;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int BIT_DONE_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_ERASE_TOGGLE = 2;

  // unlock addresses and command codes written to the flash
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 19'h002AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROG = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_ERASE = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECT = 8'h30;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 8'hB0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 8'h30;
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;

  // operations that software can order
  typedef enum logic [CTRL_OP_W-1:0] {
    OP_READ, OP_PROG, OP_SECT_ERASE, OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_RESET
  } fpc_op_t;
endpackage : fpc_pkg

//--- include/fpc_cyc_if.sv
// Purpose: carries one flash bus cycle request between sequencer and cycle engine
// Assumes: req is a one-cycle pulse issued only while busy is low
// Notes: done pulses once per cycle, rdata is valid with it
`timescale 1ns/1ps
interface fpc_cyc_if;
  logic req;
  logic wr;
  logic [fpc_pkg::ADDR_W-1:0] addr;
  logic [fpc_pkg::DATA_W-1:0] wdata;
  logic busy;
  logic done;
  logic [fpc_pkg::DATA_W-1:0] rdata;
  modport seq (output req, wr, addr, wdata, input busy, done, rdata);
  modport engine (input req, wr, addr, wdata, output busy, done, rdata);
endinterface : fpc_cyc_if

//--- rtl/fpc_cycle.sv
// Purpose: performs single read or write cycles on the flash strobe pins
// Assumes: flash strobes are asynchronous, timing met by whole-cycle counts
// Notes: data bus is only driven while output gate is high, so no contention
`timescale 1ns/1ps
module fpc_cycle (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request from sequencer
  fpc_cyc_if.engine cyc,
  // flash pins
  output logic [fpc_pkg::ADDR_W-1:0] flash_addr,
  output logic [fpc_pkg::DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [fpc_pkg::DATA_W-1:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fpc_cst_t;
  fpc_cst_t cst_q;
  logic [3:0] cnt_q;
  logic wr_q;
  logic done_q;
  logic [fpc_pkg::DATA_W-1:0] rdata_q;

  assign cyc.busy = (cst_q != C_IDLE);
  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;

  // cycle sequencing: address setup, strobe, release with hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cst_q <= C_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      flash_addr <= '0;
      flash_dq_o <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      done_q <= 1'b0;
      case (cst_q)
        C_IDLE: begin
          if (cyc.req) begin
            flash_addr <= cyc.addr; // see RULE3 RULE18
            flash_dq_o <= cyc.wdata;
            flash_dq_oe <= cyc.wr; // see RULE6
            wr_q <= cyc.wr;
            cnt_q <= fpc_pkg::AS_CYC;
            cst_q <= C_SETUP;
          end
        end
        C_SETUP: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            flash_ce_n <= 1'b0;
            flash_we_n <= !wr_q; // see RULE7
            flash_oe_n <= wr_q; // see RULE6
            cnt_q <= wr_q ? fpc_pkg::WP_CYC : fpc_pkg::ACC_CYC;
            cst_q <= C_STROBE;
          end
        end
        C_STROBE: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            if (!wr_q) begin
              rdata_q <= flash_dq_i; // sampled before the gate rises
            end
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_q <= fpc_pkg::HOLD_CYC;
            cst_q <= C_HOLD;
          end
        end
        C_HOLD: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            flash_dq_oe <= 1'b0; // data held past the write strobe edge
            done_q <= 1'b1;
            cst_q <= C_IDLE;
          end
        end
        default: cst_q <= C_IDLE;
      endcase
    end
  end
endmodule : fpc_cycle

//--- rtl/fpc_host.sv
// Purpose: host controller that drives command sequences into a parallel flash
// Assumes: AXI4-Lite software port, flash starts in array-read mode
// Notes: completion is found by toggle polling, there is no busy pin
// Overview of operation
// RULE1: flash holds 524,288 byte locations
// RULE2: eight 64-Kbyte sectors, each erasable alone
// RULE3: host drives 19-bit address, bytes both ways
// RULE4: erase sector toggle bit reported to software
// RULE5: suspended erase allows other-sector reads, programs; here erase holds busy to the end, so suspend is refused
// RULE6: strobes sequenced, bus never driven by both
// RULE7: commands are plain write cycles to flash
// RULE8: flash latches address and data per write
// RULE9: program sequence then flash self-times programming
// RULE10: erase sequence then flash preprograms and erases
// RULE11: status reads show done poll, toggle bits
// RULE12: after completion flash accepts new commands
// RULE13: other sectors unchanged by sector operations
// RULE14: erase any sector subset or whole chip
// RULE15: protected sectors refuse program and erase
// RULE16: flash reads array after reset, no command
// RULE17: flash floats data while output gate high
// RULE18: sector named by upper address lines
// RULE19: toggle bit inverts each read while busy
`timescale 1ns/1ps
module fpc_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  output logic [fpc_pkg::ADDR_W-1:0] flash_addr,
  output logic [fpc_pkg::DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [fpc_pkg::DATA_W-1:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  // interrupt
  output logic irq
);
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_FIN} fpc_st_t;
  typedef enum logic [1:0] {PH_SEQ, PH_POLL1, PH_POLL2} fpc_ph_t;

  fpc_cyc_if cyc ();
  fpc_st_t st_q;
  fpc_ph_t ph_q;
  fpc_pkg::fpc_op_t op_q;
  logic [2:0] step_q;
  logic [3:0] sect_q;
  logic [fpc_pkg::ADDR_W-1:0] addr_q;
  logic [fpc_pkg::DATA_W-1:0] wdata_q;
  logic [fpc_pkg::NUM_SECT-1:0] sect_sel_q;
  logic [fpc_pkg::DATA_W-1:0] result_q;
  logic [fpc_pkg::DATA_W-1:0] first_q;
  logic [fpc_pkg::IRQ_W-1:0] irq_stat_q;
  logic [fpc_pkg::IRQ_W-1:0] irq_en_q;
  logic req_q;
  logic cwr_q;
  logic [fpc_pkg::ADDR_W-1:0] caddr_q;
  logic [fpc_pkg::DATA_W-1:0] cdata_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_fire;
  logic start;
  logic refused;
  logic op_done;

  // merge a write into a register image under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // number of plain command writes before polling or sector naming
  function automatic logic [2:0] seq_len(input fpc_pkg::fpc_op_t op);
    case (op)
      fpc_pkg::OP_READ: return 3'd0;
      fpc_pkg::OP_PROG: return 3'd4;
      fpc_pkg::OP_SECT_ERASE: return 3'd5;
      fpc_pkg::OP_CHIP_ERASE: return 3'd6;
      default: return 3'd1;
    endcase
  endfunction : seq_len

  // address and data of each command write of an operation
  function automatic logic [fpc_pkg::ADDR_W+fpc_pkg::DATA_W-1:0] seq_word(
      input fpc_pkg::fpc_op_t op, input logic [2:0] step,
      input logic [fpc_pkg::ADDR_W-1:0] a, input logic [fpc_pkg::DATA_W-1:0] d);
    case (step)
      3'd0: if (op == fpc_pkg::OP_PROG || op == fpc_pkg::OP_SECT_ERASE ||
                op == fpc_pkg::OP_CHIP_ERASE) return {fpc_pkg::UNLOCK_A1, fpc_pkg::CMD_UNLOCK1};
      3'd1, 3'd4: return {fpc_pkg::UNLOCK_A2, fpc_pkg::CMD_UNLOCK2};
      3'd2: return {fpc_pkg::UNLOCK_A1,
                    (op == fpc_pkg::OP_PROG) ? fpc_pkg::CMD_PROG : fpc_pkg::CMD_ERASE};
      3'd3: return (op == fpc_pkg::OP_PROG) ? {a, d} : {fpc_pkg::UNLOCK_A1, fpc_pkg::CMD_UNLOCK1};
      default: return {fpc_pkg::UNLOCK_A1, fpc_pkg::CMD_CHIP};
    endcase
    case (op)
      fpc_pkg::OP_SUSPEND: return {a, fpc_pkg::CMD_SUSPEND};
      fpc_pkg::OP_RESUME: return {a, fpc_pkg::CMD_RESUME};
      default: return {a, fpc_pkg::CMD_RESET};
    endcase
  endfunction : seq_word

  assign cyc.req = req_q;
  assign cyc.wr = cwr_q;
  assign cyc.addr = caddr_q;
  assign cyc.wdata = cdata_q;

  fpc_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .cyc(cyc),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );

  // write handshake: address and data taken in either order, answered together
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign start = wr_fire && (awaddr_q == fpc_pkg::OFF_CTRL) && (st_q == S_IDLE);
  assign refused = wr_fire && (awaddr_q == fpc_pkg::OFF_CTRL) && (st_q != S_IDLE);
  assign op_done = (st_q == S_FIN);
  assign s_axi_arready = !s_axi_rvalid;

  // axi write path and software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      addr_q <= '0;
      wdata_q <= 8'h00;
      sect_sel_q <= 8'h00;
      irq_en_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awaddr_q)
          fpc_pkg::OFF_ADDR: addr_q <= fpc_pkg::ADDR_W'(merge(32'(addr_q), wd_q, ws_q));
          fpc_pkg::OFF_WDATA: wdata_q <= fpc_pkg::DATA_W'(merge(32'(wdata_q), wd_q, ws_q));
          fpc_pkg::OFF_SECT: sect_sel_q <= fpc_pkg::NUM_SECT'(merge(32'(sect_sel_q), wd_q, ws_q));
          fpc_pkg::OFF_IRQ_EN: irq_en_q <= fpc_pkg::IRQ_W'(merge(32'(irq_en_q), wd_q, ws_q));
          fpc_pkg::OFF_CTRL, fpc_pkg::OFF_IRQ_CLR: ;
          default: s_axi_bresp <= 2'h2; // unmapped or read-only
        endcase
      end
    end
  end

  // sticky interrupt bits; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      if (wr_fire && awaddr_q == fpc_pkg::OFF_IRQ_CLR) irq_stat_q <= irq_stat_q & ~wd_q[1:0];
      if (op_done) irq_stat_q[fpc_pkg::IRQ_DONE] <= 1'b1;
      if (refused) irq_stat_q[fpc_pkg::IRQ_REFUSED] <= 1'b1;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // axi read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        fpc_pkg::OFF_CTRL: s_axi_rdata <= 32'(op_q);
        fpc_pkg::OFF_ADDR: s_axi_rdata <= 32'(addr_q);
        fpc_pkg::OFF_WDATA: s_axi_rdata <= 32'(wdata_q);
        fpc_pkg::OFF_SECT: s_axi_rdata <= 32'(sect_sel_q);
        // result byte carries done poll, toggle and erase toggle bits
        fpc_pkg::OFF_STATUS: s_axi_rdata[fpc_pkg::ST_RESULT_LSB +: fpc_pkg::DATA_W] <= result_q; // see RULE4 RULE11
        fpc_pkg::OFF_IRQ_STAT: s_axi_rdata <= 32'(irq_stat_q);
        fpc_pkg::OFF_IRQ_EN: s_axi_rdata <= 32'(irq_en_q);
        fpc_pkg::OFF_IRQ_CLR: ;
        default: s_axi_rresp <= 2'h2;
      endcase
      if ({s_axi_araddr[7:2], 2'b00} == fpc_pkg::OFF_STATUS) begin
        s_axi_rdata[fpc_pkg::ST_BUSY] <= (st_q != S_IDLE);
      end
    end
  end

  // command sequencer: unlock writes, sector naming, then toggle polling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE; // flash assumed in array-read mode, see RULE16
      ph_q <= PH_SEQ;
      op_q <= fpc_pkg::OP_READ;
      step_q <= 3'd0;
      sect_q <= 4'h0;
      result_q <= 8'h00;
      first_q <= 8'h00;
      req_q <= 1'b0;
      cwr_q <= 1'b0;
      caddr_q <= '0;
      cdata_q <= 8'h00;
    end else begin
      req_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            op_q <= fpc_pkg::fpc_op_t'(wd_q[fpc_pkg::CTRL_OP_W-1:0]);
            step_q <= 3'd0;
            sect_q <= 4'h0;
            ph_q <= PH_SEQ;
            st_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (!cyc.busy) begin
            if (ph_q != PH_SEQ || op_q == fpc_pkg::OP_READ) begin
              req_q <= 1'b1; // plain read: array data, or status while busy, see RULE5
              cwr_q <= 1'b0;
              caddr_q <= addr_q;
              st_q <= S_WAIT;
            end else if (step_q < seq_len(op_q)) begin
              req_q <= 1'b1; // see RULE7 RULE8 RULE9 RULE10
              cwr_q <= 1'b1;
              {caddr_q, cdata_q} <= seq_word(op_q, step_q, addr_q, wdata_q);
              step_q <= step_q + 3'd1;
              st_q <= S_WAIT;
            end else if (op_q == fpc_pkg::OP_SECT_ERASE && sect_q < 4'(fpc_pkg::NUM_SECT)) begin
              sect_q <= sect_q + 4'h1; // unselected sectors skipped, see RULE14
              if (sect_sel_q[sect_q[2:0]]) begin
                req_q <= 1'b1;
                cwr_q <= 1'b1;
                caddr_q <= {sect_q[fpc_pkg::SECT_W-1:0], {fpc_pkg::SECT_LSB{1'b0}}}; // see RULE18 RULE2
                cdata_q <= fpc_pkg::CMD_SECT;
                st_q <= S_WAIT;
              end
            end else begin
              ph_q <= PH_POLL1;
            end
          end
        end
        S_WAIT: begin
          if (cyc.done) begin
            st_q <= S_ISSUE;
            if (!cwr_q) result_q <= cyc.rdata;
            if (ph_q == PH_SEQ && op_q == fpc_pkg::OP_READ) begin
              st_q <= S_FIN;
            end else if (ph_q == PH_POLL1) begin
              first_q <= cyc.rdata;
              ph_q <= PH_POLL2;
            end else if (ph_q == PH_POLL2) begin
              first_q <= cyc.rdata;
              // toggle bit frozen means finished, or refused when protected
              if (cyc.rdata[fpc_pkg::BIT_TOGGLE] == first_q[fpc_pkg::BIT_TOGGLE]) begin
                st_q <= S_FIN; // see RULE19 RULE11 RULE15
              end
            end
          end
        end
        S_FIN: st_q <= S_IDLE; // next command may follow at once, see RULE12
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule : fpc_host

//--- verif/fpc_host_monitor.sv
// Purpose: bus and strobe checks on the flash host controller ports
// Assumes: one clock, synchronous active-low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
module fpc_host_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  input wire logic [fpc_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fpc_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bus_no_fight_a: assert property (!(flash_dq_oe && !flash_oe_n))
    else $error("host drives data while output gate active");
  strobe_excl_a: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and output strobes low together");
  chip_sel_a: assert property ((!flash_we_n || !flash_oe_n) |-> !flash_ce_n)
    else $error("strobe without chip select");
  wr_pulse_a: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
    else $error("write strobe not two cycles");
  rd_pulse_a: assert property ($fell(flash_oe_n) |=> !flash_oe_n [*3] ##1 flash_oe_n)
    else $error("read strobe not four cycles");
  wr_setup_a: assert property (!flash_we_n |-> flash_dq_oe && $stable(flash_dq_o)
    && $stable(flash_addr)) else $error("write data or address moved under strobe");
  wr_hold_a: assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o))
    else $error("write data dropped at strobe end");
  rd_addr_a: assert property (!flash_oe_n |-> $stable(flash_addr))
    else $error("address moved during read");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
endmodule : fpc_host_monitor

bind fpc_host fpc_host_monitor i_fpc_host_monitor (.*);

//--- verif/fpc_flash_model.sv
// Purpose: behavioural byte-wide flash answering the host strobes
// Assumes: host keeps write data driven past the rising write strobe
// Notes: busy time counts status reads, not clock cycles
`timescale 1ns/1ps
module fpc_flash_model #(
  parameter logic [7:0] PROT_MASK = 8'h20,
  parameter int BUSY_READS = 5
) (
  // host bus
  input wire logic [18:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  // data towards the host
  output logic [7:0] flash_dq_i
);
  logic [7:0] mem [0:524287];
  logic [7:0] cur;
  logic [7:0] last_q = 8'h00;
  logic [7:0] ers_q = 8'h00;
  logic tog_q = 1'b0;
  logic etog_q = 1'b0;
  int step = 0;
  int busy = 0;
  // shipped fully erased
  initial for (int k = 0; k < 524288; k++) mem[k] = 8'hFF;
  // protected sectors keep data; erase sets all ones
  task automatic erase(input int s);
    if (!PROT_MASK[s])
      for (int k = 0; k < 65536; k++) mem[s * 65536 + k] = 8'hFF;
  endtask : erase
  // commands are write cycles; address and data latched at the rising strobe
  always @(posedge flash_we_n) begin
    if (flash_dq_oe && (busy == 0 || step == 7 || step == 9)) begin
      if (flash_dq_o == 8'hF0) step = 0;
      else case (step)
        0: step = (flash_addr == 19'h00555 && flash_dq_o == 8'hAA) ? 1 : 0;
        1: step = (flash_addr == 19'h002AA && flash_dq_o == 8'h55) ? 2 : 0;
        2: step = (flash_dq_o == 8'hA0) ? 3 : (flash_dq_o == 8'h80) ? 4 : 0;
        3: begin
          if (!PROT_MASK[flash_addr[18:16]]) mem[flash_addr] &= flash_dq_o;
          busy = BUSY_READS;
          step = 0;
        end
        4: step = (flash_dq_o == 8'hAA) ? 5 : 0;
        5: step = (flash_dq_o == 8'h55) ? 6 : 0;
        default: begin
          if (step == 6 && flash_dq_o == 8'h10) begin
            for (int s = 0; s < 8; s++) erase(s);
            ers_q = 8'hFF;
            busy = BUSY_READS;
            step = 8;
          end else if (flash_dq_o == 8'h30 && step < 9) begin
            erase(flash_addr[18:16]);
            ers_q[flash_addr[18:16]] = 1'b1;
            busy = BUSY_READS;
            step = 7;
          end else step = (flash_dq_o == 8'hB0) ? 9 : (flash_dq_o == 8'h30) ? 7 : 0;
        end
      endcase
    end
  end
  // status byte while busy and not suspended, array data otherwise
  always @* begin
    if (busy > 0 && step != 9) cur = {1'b0, tog_q, 3'b000, etog_q, 2'b00};
    else cur = mem[flash_addr];
  end
  // released bus shows the inverse of the last byte
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? cur : ~last_q;
  // each finished read while busy and not suspended advances the toggle bit and the busy count, and the erase toggle only in an erasing sector
  always @(posedge flash_oe_n) begin
    if (!$isunknown(cur)) last_q = cur;
    if (busy > 0 && step != 9) begin
      tog_q = ~tog_q;
      if (ers_q[flash_addr[18:16]]) etog_q = ~etog_q;
      busy--;
      if (busy == 0) ers_q = 8'h00;
      if (busy == 0) step = 0;
    end
  end
endmodule : fpc_flash_model

//--- verif/tb_parallel_flash_command_core.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model at the pins
// Notes: sector 5 is protected, so its bytes must never change
`timescale 1ns/1ps
module tb_parallel_flash_command_core;
  localparam logic [7:0] PROT = 8'h20;
  logic aclk, irq, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flash_dq_o, flash_dq_i;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [18:0] flash_addr;
  logic [7:0] exp_mem [0:524287];
  logic [18:0] addrs [$];
  logic irq_en = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  fpc_host i_fpc_host (.*);
  fpc_flash_model #(.PROT_MASK(PROT)) i_fpc_flash_model (.*);
  // free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // bready raised with the request; each channel dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // start an operation, poll busy, check and clear its interrupt, update expectations
  task automatic do_op(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d,
                       input logic [7:0] m, input logic dbl);
    logic [31:0] r;
    logic [1:0] rs;
    axi_wr(8'h04, {13'h0, a}, rs);
    axi_wr(8'h08, {24'h0, d}, rs);
    axi_wr(8'h0C, {24'h0, m}, rs);
    axi_wr(8'h00, {29'h0, op}, rs);
    if (dbl) axi_wr(8'h00, 32'h1, rs);
    r = 32'h1;
    for (int n = 0; n < 400 && r[0] !== 1'b0; n++) axi_rd(8'h10, r, rs);
    chk("busy", {31'h0, r[0]}, 32'h0);
    axi_rd(8'h14, r, rs);
    chk("irq_stat", r, {30'h0, dbl, 1'b1});
    chk("irq", {31'h0, irq}, {31'h0, irq_en});
    axi_wr(8'h18, 32'h3, rs);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    if (op == 3'd1 && !PROT[a[18:16]]) exp_mem[a] &= d;
    for (int s = 0; s < 8; s++)
      if (!PROT[s] && (op == 3'd3 || (op == 3'd2 && m[s])))
        for (int k = 0; k < 65536; k++) exp_mem[s * 65536 + k] = 8'hFF;
  endtask : do_op
  task automatic check_byte(input logic [18:0] a);
    logic [31:0] r;
    logic [1:0] rs;
    do_op(3'd0, a, 8'h00, 8'h00, 1'b0);
    axi_rd(8'h10, r, rs);
    chk("array", {24'h0, r[15:8]}, {24'h0, exp_mem[a]});
  endtask : check_byte
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    irq_en = 1'b0;
  endtask : do_reset
  // control, status and interrupt registers read zero after reset
  task automatic check_regs();
    logic [7:0] offs [4] = '{8'h00, 8'h10, 8'h14, 8'h1C};
    logic [31:0] r;
    logic [1:0] rs;
    foreach (offs[i]) begin
      axi_rd(offs[i], r, rs);
      chk("reset_reg", r, 32'h0);
    end
  endtask : check_regs
  // hang guard, well above the expected run time
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    logic [1:0] rs;
    logic [18:0] a;
    void'($urandom(32'h2a3fd05f));
    for (int k = 0; k < 524288; k++) exp_mem[k] = 8'hFF;
    do_reset();
    check_regs();
    axi_rd(8'h20, r, rs);
    chk("unmapped", {r[29:0], rs}, 32'h2);
    axi_wr(8'h10, 32'h1, rs);
    chk("ro_write", {30'h0, rs}, 32'h2);
    axi_wr(8'h1C, 32'h1, rs);
    irq_en = 1'b1;
    check_byte(19'($urandom));
    for (int i = 0; i < 8; i++) begin
      a = (i == 7) ? 19'h7FFFF : {i[2:0], 16'($urandom)};
      addrs.push_back(a);
      do_op(3'd1, a, 8'($urandom), 8'h00, 1'b0);
      check_byte(a);
    end
    do_reset();
    check_regs();
    do_op(3'd2, 19'h0, 8'h00, 8'h2A, 1'b0);
    foreach (addrs[i]) check_byte(addrs[i]);
    for (int op = 4; op < 7; op++) do_op(3'(op), addrs[2], 8'h00, 8'h00, 1'b0);
    do_op(3'd3, 19'h0, 8'h00, 8'h00, 1'b1);
    foreach (addrs[i]) check_byte(addrs[i]);
    end_of_test();
  end
endmodule : tb_parallel_flash_command_core
